// ### core/modem_power_pkg.sv
// package of register map, field layout and timing constants for modem power control
package modem_power_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned ENABLE_SETTLE_US = 2_000;      // regulator ready after release
  localparam int unsigned TOGGLE_ON_MS = 3_000;          // low time that powers on
  localparam int unsigned TOGGLE_OFF_MS = 2_000;         // low time that powers off
  localparam int unsigned LED_SLOW_ON_MS = 300;
  localparam int unsigned LED_SLOW_OFF_MS = 2_700;
  localparam int unsigned LED_FAST_MS = 500;
  localparam int unsigned SHUTDOWN_NOTIFY_MS = 1_000;    // network detach window
  localparam int unsigned ENABLE_SETTLE_CYC = ENABLE_SETTLE_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned TOGGLE_ON_CYC = TOGGLE_ON_MS * (CLOCK_HZ / 1_000);
  localparam int unsigned TOGGLE_OFF_CYC = TOGGLE_OFF_MS * (CLOCK_HZ / 1_000);
  localparam int unsigned LED_SLOW_ON_CYC = LED_SLOW_ON_MS * (CLOCK_HZ / 1_000);
  localparam int unsigned LED_SLOW_OFF_CYC = LED_SLOW_OFF_MS * (CLOCK_HZ / 1_000);
  localparam int unsigned LED_FAST_CYC = LED_FAST_MS * (CLOCK_HZ / 1_000);
  localparam int unsigned SHUTDOWN_NOTIFY_CYC = SHUTDOWN_NOTIFY_MS * (CLOCK_HZ / 1_000);
  localparam int unsigned COUNT_W = 32;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_GPIO_DIR = 8'h08;
  localparam logic [ADDR_W-1:0] REG_GPIO_OUT = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_GPIO_IN = 8'h10;

  // control fields
  localparam int unsigned CTRL_SHUTDOWN_CMD = 0;   // write 1: controlled power-down
  localparam int unsigned CTRL_LED_SELECT = 1;     // pin 0 carries status led
  localparam int unsigned CTRL_REGISTERED = 2;     // radio reports registration
  localparam logic [2:0] CONTROL_RESET = 3'h0;

  // status fields
  localparam int unsigned STAT_POWERED = 0;
  localparam int unsigned STAT_REG_READY = 1;
  localparam int unsigned STAT_IN_RESET = 2;
  localparam int unsigned STAT_SHUTTING = 3;
  localparam int unsigned STAT_SEARCHING = 4;

  localparam int unsigned GPIO_COUNT = 7;
  localparam int unsigned LED_PIN = 0;

  // ************************************************************
  // power sequencing states
  // ************************************************************
  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_ON = 2'b01,
    PWR_SHUTDOWN = 2'b10
  } power_state_t;

  typedef enum logic [1:0] {
    LED_DARK = 2'b00,
    LED_STEADY = 2'b01,
    LED_SLOW = 2'b10,
    LED_FAST = 2'b11
  } led_mode_t;

endpackage

// ### core/status_led_blinker.sv
// status led pattern generator: dark, steady, slow blink, fast blink
module status_led_blinker
  import modem_power_pkg::*;
#(
  parameter int unsigned SLOW_ON = LED_SLOW_ON_CYC,
  parameter int unsigned SLOW_OFF = LED_SLOW_OFF_CYC,
  parameter int unsigned FAST = LED_FAST_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // pattern select
  input wire led_mode_t i_mode,
  // led level
  output logic o_led
);

  logic [COUNT_W-1:0] phase_count;
  led_mode_t last_mode;
  logic [COUNT_W-1:0] phase_len;

  // ************************************************************
  // phase length
  // ************************************************************
  always_comb begin
    if (i_mode == LED_FAST) begin
      phase_len = COUNT_W'(FAST);
    end else if (o_led) begin
      phase_len = COUNT_W'(SLOW_ON);
    end else begin
      phase_len = COUNT_W'(SLOW_OFF);
    end
  end

  // pattern restarts lit whenever the mode changes to anything but dark, and dark when it changes to dark
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_led <= 1'b0;
      phase_count <= '0;
      last_mode <= LED_DARK;
    end else begin
      last_mode <= i_mode;
      if (i_mode != last_mode) begin
        o_led <= (i_mode != LED_DARK);
        phase_count <= '0;
      end else if (i_mode == LED_DARK) begin
        o_led <= 1'b0;
      end else if (i_mode == LED_STEADY) begin
        o_led <= 1'b1;
      end else if (phase_count + 1'b1 >= phase_len) begin
        o_led <= ~o_led;
        phase_count <= '0;
      end else begin
        phase_count <= phase_count + 1'b1;
      end
    end
  end

endmodule

// ### core/modem_power_control.sv
// modem power, reset, power toggle, monitor, aux supply, status led and gpio control
//
// The address map and the Wishbone register port were chosen for this implementation.
module modem_power_control
  import modem_power_pkg::*;
#(
  parameter int unsigned GPIO_N = GPIO_COUNT,
  parameter int unsigned SETTLE_CYCLES = ENABLE_SETTLE_CYC,
  parameter int unsigned ON_HOLD_CYCLES = TOGGLE_ON_CYC,
  parameter int unsigned OFF_HOLD_CYCLES = TOGGLE_OFF_CYC,
  parameter int unsigned NOTIFY_CYCLES = SHUTDOWN_NOTIFY_CYC,
  parameter int unsigned LED_SLOW_ON = LED_SLOW_ON_CYC,
  parameter int unsigned LED_SLOW_OFF = LED_SLOW_OFF_CYC,
  parameter int unsigned LED_FAST_HALF = LED_FAST_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // control pins, pulled high inside, low when host drives
  input wire logic i_supply_enable,
  input wire logic i_reset_pin,
  input wire logic i_power_toggle,
  // power outputs
  output logic o_regulator_on,
  output logic o_regulator_ready,
  output logic o_modem_reset_n,
  output logic power_monitor_out_unused_name_guard,
  output logic o_power_monitor_out,
  output logic o_aux_supply_out,
  output logic o_network_detach,
  // logic inputs of host held high during power-down
  input wire logic i_host_inputs_high,
  // general purpose pads
  input wire logic [GPIO_N-1:0] i_gpio,
  output logic [GPIO_N-1:0] o_gpio,
  output logic [GPIO_N-1:0] o_gpio_oe
);

  power_state_t state;
  power_state_t next_state;
  logic [COUNT_W-1:0] settle_count;
  logic [COUNT_W-1:0] low_count;
  logic [COUNT_W-1:0] notify_count;
  logic toggle_last;
  logic toggle_release;
  logic toggle_on_req;
  logic toggle_off_req;
  logic [2:0] control;
  logic shutdown_req;
  logic [GPIO_N-1:0] gpio_dir;
  logic [GPIO_N-1:0] gpio_out;
  logic [GPIO_N-1:0] gpio_in;
  logic led_level;
  led_mode_t led_mode;
  logic wb_req;
  logic wb_wr;
  logic [31:0] read_word;
  logic in_reset;

  assign power_monitor_out_unused_name_guard = 1'b0;
  assign in_reset = ~i_reset_pin;

  // ************************************************************
  // regulator enable and settle timer
  // ************************************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_regulator_on <= 1'b0;
      o_regulator_ready <= 1'b0;
      settle_count <= '0;
    end else if (!i_supply_enable) begin
      o_regulator_on <= 1'b0;
      o_regulator_ready <= 1'b0;
      settle_count <= '0;
    end else begin
      o_regulator_on <= 1'b1;
      if (settle_count + 1'b1 >= COUNT_W'(SETTLE_CYCLES)) begin
        o_regulator_ready <= 1'b1;
      end else begin
        settle_count <= settle_count + 1'b1;
      end
    end
  end

  // reset pin, gated by regulator ready, passes to the modem core, registered
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_modem_reset_n <= 1'b0;
    end else begin
      o_modem_reset_n <= i_reset_pin & o_regulator_ready;
    end
  end

  // ************************************************************
  // power toggle low-time measurement
  // ************************************************************
  // a release is a rising edge; the held time is judged only then
  assign toggle_release = i_power_toggle & ~toggle_last;
  assign toggle_on_req = toggle_release && (low_count >= COUNT_W'(ON_HOLD_CYCLES));
  assign toggle_off_req = toggle_release && (low_count >= COUNT_W'(OFF_HOLD_CYCLES));

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      toggle_last <= 1'b1;
      low_count <= '0;
    end else begin
      toggle_last <= i_power_toggle;
      if (i_power_toggle) begin
        low_count <= '0;
      end else if (low_count != '1) begin
        low_count <= low_count + 1'b1; // saturates rather than wraps
      end
    end
  end

  // ************************************************************
  // power state machine
  // ************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      PWR_OFF: begin
        if (toggle_on_req && o_regulator_ready) begin
          next_state = PWR_ON;
        end
      end
      PWR_ON: begin
        if (toggle_off_req || shutdown_req) begin
          next_state = PWR_SHUTDOWN;
        end
      end
      PWR_SHUTDOWN: begin
        // stays up while host still drives logic inputs high
        if (notify_count + 1'b1 >= COUNT_W'(NOTIFY_CYCLES) && !i_host_inputs_high) begin
          next_state = PWR_OFF;
        end
      end
      default: begin
        next_state = PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || !o_regulator_on || in_reset) begin
      state <= PWR_OFF;
      notify_count <= '0;
    end else begin
      state <= next_state;
      if (state == PWR_SHUTDOWN && notify_count + 1'b1 < COUNT_W'(NOTIFY_CYCLES)) begin
        notify_count <= notify_count + 1'b1;
      end else if (state != PWR_SHUTDOWN) begin
        notify_count <= '0;
      end
    end
  end

  // monitor, aux supply and detach notice all from one state
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_power_monitor_out <= 1'b0;
      o_aux_supply_out <= 1'b0;
      o_network_detach <= 1'b0;
    end else begin
      o_power_monitor_out <= (next_state != PWR_OFF) && o_regulator_on && !in_reset;
      o_aux_supply_out <= (next_state != PWR_OFF) && o_regulator_on && !in_reset;
      // follows next_state so detach never outlives the monitor on the way down
      o_network_detach <= (next_state == PWR_SHUTDOWN) && o_regulator_on && !in_reset;
    end
  end

  // ************************************************************
  // status led
  // ************************************************************
  always_comb begin
    unique case (state)
      PWR_ON: led_mode = control[CTRL_REGISTERED] ? LED_SLOW : LED_STEADY;
      PWR_SHUTDOWN: led_mode = LED_FAST;
      default: led_mode = LED_DARK;
    endcase
  end

  status_led_blinker #(
    .SLOW_ON(LED_SLOW_ON),
    .SLOW_OFF(LED_SLOW_OFF),
    .FAST(LED_FAST_HALF)
  ) u_blinker (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_mode(led_mode),
    .o_led(led_level)
  );

  // ************************************************************
  // gpio pads
  // ************************************************************
  generate
    for (genvar g = 0; g < GPIO_N; g++) begin : g_pad
      always_ff @(posedge i_clock) begin
        if (i_reset) begin
          o_gpio[g] <= 1'b0;
          o_gpio_oe[g] <= 1'b0;
          gpio_in[g] <= 1'b0;
        end else if (g == LED_PIN && control[CTRL_LED_SELECT]) begin
          o_gpio[g] <= led_level;
          o_gpio_oe[g] <= 1'b1;
          gpio_in[g] <= i_gpio[g];
        end else begin
          o_gpio[g] <= gpio_out[g]; // push-pull: both levels driven
          o_gpio_oe[g] <= gpio_dir[g];
          gpio_in[g] <= i_gpio[g];
        end
      end
    end
  endgenerate

  // ************************************************************
  // wishbone slave
  // ************************************************************
  // one wait state keeps read data registered; ack drops after one cycle
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wb_wr = wb_req & i_wb_we & i_wb_sel[0];

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= wb_req;
    end
  end

  always_comb begin
    read_word = '0;
    unique case (i_wb_adr)
      REG_CONTROL: read_word[2:0] = control;
      REG_STATUS: begin
        read_word[STAT_POWERED] = o_power_monitor_out;
        read_word[STAT_REG_READY] = o_regulator_ready;
        read_word[STAT_IN_RESET] = in_reset;
        read_word[STAT_SHUTTING] = (state == PWR_SHUTDOWN);
        read_word[STAT_SEARCHING] = (led_mode == LED_STEADY);
      end
      REG_GPIO_DIR: read_word[GPIO_N-1:0] = gpio_dir;
      REG_GPIO_OUT: read_word[GPIO_N-1:0] = gpio_out;
      REG_GPIO_IN: read_word[GPIO_N-1:0] = gpio_in;
      default: read_word = '0;      // unmapped reads zero
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_wb_dat <= '0;
    end else if (wb_req) begin
      o_wb_dat <= read_word;
    end
  end

  // register writes; shutdown command is a self-clearing pulse
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      control <= CONTROL_RESET;
      gpio_dir <= '0;
      gpio_out <= '0;
      shutdown_req <= 1'b0;
    end else begin
      shutdown_req <= wb_wr && (i_wb_adr == REG_CONTROL) && i_wb_dat[CTRL_SHUTDOWN_CMD];
      if (wb_wr && i_wb_adr == REG_CONTROL) begin
        control <= {i_wb_dat[CTRL_REGISTERED], i_wb_dat[CTRL_LED_SELECT], 1'b0};
      end
      if (wb_wr && i_wb_adr == REG_GPIO_DIR) begin
        gpio_dir <= i_wb_dat[GPIO_N-1:0];
      end
      if (wb_wr && i_wb_adr == REG_GPIO_OUT) begin
        gpio_out <= i_wb_dat[GPIO_N-1:0];
      end
    end
  end

endmodule

// ### sim/modem_power_monitor.sv
// checker for the power, reset, monitor and aux supply pins of modem_power_control
module modem_power_monitor #(
  parameter int unsigned SETTLE_CYCLES = 20
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_supply_enable,
  input wire logic i_reset_pin,
  input wire logic i_power_toggle,
  input wire logic i_host_inputs_high,
  input wire logic o_regulator_on,
  input wire logic o_regulator_ready,
  input wire logic o_modem_reset_n,
  input wire logic o_power_monitor_out,
  input wire logic o_aux_supply_out,
  input wire logic o_network_detach
);
  // ************************************************************
  // assertions and covers
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  logic [15:0] up_cnt;
  // cycles since supply enable was last seen low; saturates so it never wraps
  always_ff @(posedge i_clock) begin
    if (i_reset || !i_supply_enable) begin
      up_cnt <= 16'h0;
    end else if (up_cnt != 16'hffff) begin
      up_cnt <= up_cnt + 16'h1;
    end
  end
  a_regulator_follow: assert property (1'b1 |=> o_regulator_on == $past(i_supply_enable))
    else $error("regulator does not follow supply enable");
  a_ready_settle: assert property ($rose(o_regulator_ready) |->
      up_cnt + 16'h1 >= 16'(SETTLE_CYCLES) && up_cnt <= 16'(SETTLE_CYCLES) + 16'h2)
    else $error("regulator ready at wrong time");
  a_ready_drop: assert property (!i_supply_enable |=> !o_regulator_ready)
    else $error("regulator ready while supply disabled");
  a_reset_hold: assert property (!i_reset_pin |=> !o_modem_reset_n)
    else $error("modem not held in reset");
  a_aux_follow: assert property (o_aux_supply_out == o_power_monitor_out)
    else $error("aux supply differs from monitor");
  a_monitor_off: assert property (!i_supply_enable |-> ##2 !o_power_monitor_out)
    else $error("monitor high while powered down");
  a_change_release: assert property ($rose(o_power_monitor_out) |->
      $past(i_power_toggle) && !$past(i_power_toggle, 2))
    else $error("power on without toggle release");
  a_inputs_keep_on: assert property ((i_supply_enable && i_reset_pin && i_host_inputs_high)[*2]
      ##0 o_power_monitor_out |=> o_power_monitor_out)
    else $error("monitor fell while inputs driven high");
  a_detach_monitor: assert property (o_network_detach |-> o_power_monitor_out)
    else $error("network detach while powered down");
  c_power_on: cover property ($rose(o_power_monitor_out));
  c_detach: cover property ($rose(o_network_detach));
  c_power_off: cover property ($fell(o_power_monitor_out));
endmodule

// ### sim/host_pin_model.sv
// host controller model driving the open-drain control pins of the modem
module host_pin_model (
  // clock
  input wire logic i_clock,
  // open-drain pins as seen at the device
  output logic o_supply_enable,
  output logic o_reset_pin,
  output logic o_power_toggle,
  // host logic inputs still driven high
  output logic o_host_inputs_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // pin drive
  // ************************************************************
  logic [2:0] pull_low = 3'h0;
  logic drive_high = 1'b0;
  // a released pin reads the internal pull-up, the host never drives high
  assign o_supply_enable = !pull_low[0];
  assign o_reset_pin = !pull_low[1];
  assign o_power_toggle = !pull_low[2];
  assign o_host_inputs_high = drive_high;
  // hold one pin low for whole cycles, then release; caller picks the length
  task automatic press(input int pin, input int cycles);
    @(posedge i_clock);
    pull_low[pin] <= 1'b1;
    repeat (cycles) @(posedge i_clock);
    pull_low[pin] <= 1'b0;
  endtask
  // keep or stop driving logic inputs high
  task automatic hold_inputs(input logic v);
    @(posedge i_clock);
    drive_high <= v;
  endtask
endmodule

// ### sim/modem_power_control_tb_top.sv
// testbench for modem_power_control with host pin model and bus tasks
module modem_power_control_tb_top import modem_power_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // signals and design
  // ************************************************************
  localparam int ST = 20;
  localparam int SON = 3;
  localparam int FH = 5;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sup_en, rst_pin, tog, host_hi;
  logic reg_on, reg_rdy, modem_rst_n, mon, aux, detach;
  logic [ADDR_W-1:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat_w = 32'h0, wb_rdat, rdat;
  logic [6:0] gpio_in = 7'h00, gpio_out, gpio_oe;
  int num_errors = 0;
  int num_checks = 0;
  int ones;
  modem_power_control #(.SETTLE_CYCLES(ST), .ON_HOLD_CYCLES(30), .OFF_HOLD_CYCLES(20),
    .NOTIFY_CYCLES(10), .LED_SLOW_ON(SON), .LED_SLOW_OFF(27), .LED_FAST_HALF(FH)) dut_u (
    .i_clock(i_clock), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat_w), .o_wb_dat(wb_rdat), .o_wb_ack(ack),
    .i_supply_enable(sup_en), .i_reset_pin(rst_pin), .i_power_toggle(tog),
    .o_regulator_on(reg_on), .o_regulator_ready(reg_rdy), .o_modem_reset_n(modem_rst_n),
    .power_monitor_out_unused_name_guard(), .o_power_monitor_out(mon),
    .o_aux_supply_out(aux), .o_network_detach(detach), .i_host_inputs_high(host_hi),
    .i_gpio(gpio_in), .o_gpio(gpio_out), .o_gpio_oe(gpio_oe));
  host_pin_model host_u (.i_clock(i_clock), .o_supply_enable(sup_en), .o_reset_pin(rst_pin),
    .o_power_toggle(tog), .o_host_inputs_high(host_hi));
  // free-running clock
  always #10 i_clock = ~i_clock;
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic fail(input string msg);
    chk(1'b0, 1'b1, msg);
    end_sim();
  endtask
  // one classic cycle; holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    for (int n = 0; ack !== 1'b1; n++) begin
      if (n == 50) fail("no bus answer");
      @(posedge i_clock);
    end
    rdat = wb_rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_mon(input logic v);
    for (int n = 0; mon !== v; n++) begin
      if (n == 200) fail("monitor never changed");
      @(posedge i_clock);
    end
  endtask
  // counts led high cycles; robust to the phase of the pattern
  task automatic count_led(input int cycles);
    ones = 0;
    repeat (cycles) begin
      @(posedge i_clock);
      ones += int'(gpio_out[0] === 1'b1);
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regulator();
    int n;
    n = 0;
    fork
      host_u.press(0, 12);
      begin
        repeat (4) @(posedge i_clock);
        chk(reg_on, 1'b0, "regulator on");
        chk(reg_rdy, 1'b0, "ready early");
      end
    join
    while (reg_rdy !== 1'b1 && n < 100) begin
      @(posedge i_clock);
      n++;
    end
    chk(n >= ST - 1 && n <= ST + 3, 1'b1, "settle time");
    chk(reg_on, 1'b1, "regulator off");
  endtask
  task automatic t_reset_pin();
    fork
      host_u.press(1, 10);
      begin
        repeat (3) @(posedge i_clock);
        chk(modem_rst_n, 1'b0, "modem not in reset");
      end
    join
    repeat (3) @(posedge i_clock);
    chk(modem_rst_n, 1'b1, "modem stuck in reset");
  endtask
  task automatic t_power_on();
    host_u.press(2, 8);
    repeat (6) @(posedge i_clock);
    chk(mon, 1'b0, "short pulse acted");
    host_u.press(2, 32);
    chk(mon, 1'b0, "acted before release");
    wait_mon(1'b1);
    chk(aux, 1'b1, "aux off while on");
    wb(1'b0, REG_STATUS, 32'h0);
    chk(rdat[STAT_POWERED], 1'b1, "status powered");
  endtask
  task automatic t_led_gpio();
    wb(1'b1, REG_CONTROL, 32'h2);
    count_led(8);
    chk(ones, 8, "steady led");
    chk(gpio_oe[0], 1'b1, "led pad not driven");
    wb(1'b1, REG_GPIO_DIR, 32'h7e);
    wb(1'b1, REG_GPIO_OUT, 32'h2a);
    gpio_in <= 7'h55;
    repeat (3) @(posedge i_clock);
    chk({gpio_oe[6:1], gpio_out[6:1]}, 12'hfd5, "gpio drive");
    wb(1'b0, REG_GPIO_IN, 32'h0);
    chk(rdat, 32'h55, "gpio input");
    // a write without the low byte lane selected must leave the register alone
    sel <= 4'he;
    wb(1'b1, REG_GPIO_OUT, 32'h00);
    sel <= 4'hf;
    wb(1'b0, REG_GPIO_OUT, 32'h0);
    chk(rdat, 32'h2a, "write without sel0 landed");
    wb(1'b0, 8'h14, 32'h0);
    chk(rdat, 32'h0, "unmapped read");
    wb(1'b1, REG_CONTROL, 32'h6);
    repeat (2) @(posedge i_clock);
    count_led(60);
    chk(ones, 2 * SON, "slow blink");
  endtask
  task automatic t_power_off();
    host_u.hold_inputs(1'b1);
    host_u.press(2, 24);
    repeat (3) @(posedge i_clock);
    chk(detach, 1'b1, "no network notice");
    count_led(40);
    chk(ones, 4 * FH, "fast blink");
    chk(mon, 1'b1, "monitor fell while inputs high");
    host_u.hold_inputs(1'b0);
    wait_mon(1'b0);
    chk({aux, detach}, 2'b00, "aux or detach left on");
    // blinker and pad register each add a cycle behind the monitor
    repeat (2) @(posedge i_clock);
    count_led(4);
    chk(ones, 0, "led lit while off");
  endtask
  task automatic t_command_off();
    host_u.press(2, 32);
    wait_mon(1'b1);
    wb(1'b1, REG_CONTROL, 32'h3);
    repeat (2) @(posedge i_clock);
    chk(detach, 1'b1, "command gave no notice");
    wb(1'b0, REG_CONTROL, 32'h0);
    chk(rdat, 32'h2, "command bit reads back");
    wait_mon(1'b0);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    wb(1'b0, REG_CONTROL, 32'h0);
    chk(rdat, {29'h0, CONTROL_RESET}, "control reset");
    wb(1'b0, REG_GPIO_DIR, 32'h0);
    chk(rdat | {25'h0, gpio_oe}, 32'h0, "gpio reset");
    t_regulator();
    t_reset_pin();
    t_power_on();
    t_led_gpio();
    t_power_off();
    t_command_off();
    end_sim();
  end
endmodule

bind modem_power_control modem_power_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (
  .i_clock(i_clock), .i_reset(i_reset), .i_supply_enable(i_supply_enable),
  .i_reset_pin(i_reset_pin), .i_power_toggle(i_power_toggle),
  .i_host_inputs_high(i_host_inputs_high), .o_regulator_on(o_regulator_on),
  .o_regulator_ready(o_regulator_ready), .o_modem_reset_n(o_modem_reset_n),
  .o_power_monitor_out(o_power_monitor_out), .o_aux_supply_out(o_aux_supply_out),
  .o_network_detach(o_network_detach));
